// ===== rtl/gccl_pkg.sv
// constants, codes and carrier types of the gci control channel logic
// assumes a single 50 MHz system clock; link pins are sampled, not clocked
`default_nettype none

package gccl_pkg;
	// ----------------------------------------------------------------
	// link frame and superframe timing
	// ----------------------------------------------------------------
	localparam logic [4:0] MON_FIRST_BIT = 5'h10;
	localparam logic [4:0] MON_LAST_BIT = 5'h17;
	localparam logic [4:0] CI_FIRST_BIT = 5'h1a;
	localparam logic [4:0] CI_LAST_BIT = 5'h1d;
	localparam logic [6:0] SF_LAST_FRAME = 7'h5f;
	localparam logic [1:0] MON_LAST_PHASE = 2'h3;
	localparam logic [1:0] CHK_COUNT = 2'h3;

	// ----------------------------------------------------------------
	// c/i codes, bit 4 is the msb
	// ----------------------------------------------------------------
	localparam logic [3:0] CI_DEACT_REQUEST = 4'h0;
	localparam logic [3:0] CI_CHIP_CLEAR = 4'h1;
	localparam logic [3:0] CI_SHUTDOWN_ACCEPTED = 4'h1;
	localparam logic [3:0] CI_AUX_HIGH_TWO = 4'h2;
	localparam logic [3:0] CI_AUX_HIGH_ONE = 4'h3;
	localparam logic [3:0] CI_RESYNC_NEEDED = 4'h4;
	localparam logic [3:0] CI_ERROR_NOTICE = 4'h5;
	localparam logic [3:0] CI_LINE_ONLY = 4'h7;
	localparam logic [3:0] CI_ACT_REQUEST = 4'h8;
	localparam logic [3:0] CI_ACT_LOOPBACK = 4'ha;
	localparam logic [3:0] CI_ACT_NOTICE = 4'hc;
	localparam logic [3:0] CI_LOOPBACK_ACTIVE = 4'he;
	localparam logic [3:0] CI_DEACT_DONE = 4'hf;

	// ----------------------------------------------------------------
	// indication headers and m4 bit positions
	// ----------------------------------------------------------------
	localparam logic [7:0] HDR_M56 = 8'h00;
	localparam logic [7:0] HDR_M4 = 8'h20;
	localparam logic [3:0] HDR_EOC = 4'h4;
	localparam logic [7:0] MON_IDLE = 8'hff;
	localparam int M4_ACT = 7;
	localparam int M4_DEA = 6;
	localparam int M4_UOA = 5;
	localparam int M4_SAI = 4;
	localparam logic [7:0] M4_FIXED_ONES = 8'h0f;

	// ----------------------------------------------------------------
	// register map and reset values
	// ----------------------------------------------------------------
	localparam logic [3:0] REG_CTRL = 4'h0;
	localparam logic [3:0] REG_M4_MASK = 4'h1;
	localparam logic [3:0] REG_M4_VAL = 4'h2;
	localparam logic [3:0] REG_M4_RX = 4'h3;
	localparam logic [3:0] REG_M56_RX = 4'h4;
	localparam logic [3:0] REG_EOC_LO = 4'h5;
	localparam logic [3:0] REG_EOC_HI = 4'h6;
	localparam logic [3:0] REG_STATUS = 4'h7;
	localparam logic [3:0] REG_CI = 4'h8;
	localparam logic [7:0] RST_CTRL = 8'h00;
	localparam logic [7:0] RST_M4_MASK = 8'h00;
	localparam logic [7:0] RST_M4_VAL = 8'hff;

	// ----------------------------------------------------------------
	// carrier types
	// ----------------------------------------------------------------
	typedef struct packed {
		logic stb;
		logic [7:0] m4;
		logic [7:0] m56;
	} gccl_maint_s;

	typedef struct packed {
		logic stb;
		logic [11:0] msg;
	} gccl_eoc_s;

	typedef struct packed {
		logic wr;
		logic rd;
		logic [3:0] addr;
		logic [7:0] wdata;
	} gccl_rbus_s;

	typedef enum logic [4:0] {
		ST_IDLE = 5'b00001,
		ST_WAIT = 5'b00010,
		ST_LINE = 5'b00100,
		ST_ACTIVE = 5'b01000,
		ST_DEACT = 5'b10000
	} gccl_act_e;
endpackage

`default_nettype wire

// ===== rtl/gccl_sync3.sv
// three-stage pin synchroniser with agreement filter
// assumes an asynchronous pin input and the system clock
`default_nettype none

module gccl_sync3 (
	// clock and reset
	input wire logic clock_i,
	input wire logic rst_n_i,
	// pin and synchronised level
	input wire logic pin_i,
	output logic level_o
);
	logic s1_q, s2_q, s3_q;

	// first stage feeds only the second
	always_ff @(posedge clock_i) begin
		if (!rst_n_i) begin
			s1_q <= 1'b0;
			s2_q <= 1'b0;
			s3_q <= 1'b0;
		end else begin
			s1_q <= pin_i;
			s2_q <= s1_q;
			s3_q <= s2_q;
		end
	end

	// a change counts once stages two and three agree
	always_ff @(posedge clock_i) begin
		if (!rst_n_i) begin
			level_o <= 1'b0;
		end else if (s2_q == s3_q) begin
			level_o <= s3_q;
		end
	end
endmodule

`default_nettype wire

// ===== rtl/gccl_tri_chk.sv
// triple-consecutive check of one received maintenance field
// assumes strobes come from the deframer on the system clock
`default_nettype none

module gccl_tri_chk #(
	parameter int W = 8
) (
	// clock and reset
	input wire logic clock_i,
	input wire logic rst_n_i,
	// raw samples
	input wire logic stb_i,
	input wire logic [W-1:0] val_i,
	// checked register and change pulse
	output logic [W-1:0] reg_o,
	output logic upd_o
);
	logic [W-1:0] cand_q;
	logic [1:0] cnt_q;
	logic same;

	assign same = (val_i == cand_q);

	// count identical samples, saturating at three
	always_ff @(posedge clock_i) begin
		if (!rst_n_i) begin
			cand_q <= '0;
			cnt_q <= 2'h0;
		end else if (stb_i) begin
			cand_q <= val_i;
			cnt_q <= (same && cnt_q != gccl_pkg::CHK_COUNT) ? cnt_q + 2'h1 : (same ? cnt_q : 2'h1);
		end
	end

	// only a checked value that differs updates the register
	always_ff @(posedge clock_i) begin
		if (!rst_n_i) begin
			reg_o <= '1;
			upd_o <= 1'b0;
		end else begin
			upd_o <= 1'b0;
			if (stb_i && same && cnt_q == 2'h2 && val_i != reg_o) begin
				reg_o <= val_i;
				upd_o <= 1'b1;
			end
		end
	end

	checked_update_a: assert property (@(posedge clock_i) disable iff (!rst_n_i)
		upd_o |-> $past(stb_i) && $past(cnt_q) == 2'h2 && reg_o == $past(val_i))
		else $error("maintenance register updated without triple check");
endmodule

`default_nettype wire

// ===== rtl/gccl_ctrl.sv
// gci control channel: monitor indications, c/i codes, frame sync
// assumes dcl, fsc, din and the master pin are asynchronous pins;
// deframer strobes, line status and responses are on clock_i
//
// Our own choices: the register offsets and the plain strobed port.
`default_nettype none

// Functional notes
// - send indication when maintenance register updates
// - update registers only after triple check
// - pending indications go before read responses
// - sending an indication clears its flag
// - m5/m6 indication: zero byte, then register
// - m4 indication: header bit b15, then register
// - eoc indication: b16 header, a1-dm, i1-i8
// - eoc bit a1 most, i8 least significant
// - act on c/i code seen twice
// - c/i bit 4 is msb, sent first
// - lt indications use the listed codes
// - nt commands and indications use listed codes
// - auxiliary commands hold auxiliary pins high
// - nt eoc loopback at linkup gives loopback request
// - loopback active notice repeats during loopback
// - upstream sai set suppresses line-only notice
// - m4 bits automatic unless register override
// - master pin low slave, high drives sync
// - single-clock sync every 96 frames aligns superframe
// - data after single pulse starts superframe
// - master emits single-clock sync per superframe
// - nt slave ignores superframe alignment on sync
// - indications generated on any received change; here only on a change that passed the triple check
module gccl_ctrl (
	// clock and reset
	input wire logic clock_i,
	input wire logic rst_n_i,
	// link pins
	input wire logic dcl_i,
	input wire logic fsc_i,
	input wire logic din_i,
	input wire logic master_i,
	output logic dout_o,
	output logic fsc_o,
	output logic fsc_oe_o,
	// deframer and line status
	input wire gccl_pkg::gccl_maint_s maint_i,
	input wire gccl_pkg::gccl_eoc_s eoc_i,
	input wire logic rx_sf_first_i,
	input wire logic linkup_i,
	input wire logic sync_lost_i,
	input wire logic line_err_i,
	input wire logic eoc_lpbk_i,
	input wire logic lpbk_on_i,
	output logic tx_sf_first_o,
	output logic [7:0] m4_tx_o,
	// register read responses
	input wire logic resp_valid_i,
	input wire logic [15:0] resp_msg_i,
	output logic resp_ready_o,
	// auxiliary pins
	output logic aux_output_one_o,
	output logic aux_output_two_o,
	// register port
	input wire gccl_pkg::gccl_rbus_s rbus_i,
	output logic [7:0] rb_rdata_o
);
	// ----------------------------------------------------------------
	// pin sampling and link timing
	// ----------------------------------------------------------------
	logic dcl_s, fsc_s, din_s, ms_s, dcl_d_q, fsc_d_q;
	logic dcl_rise, fsc_start, frm_edge, single_fsc_q;
	logic [4:0] bcnt_q, idx, ci_pos;
	logic [1:0] fsc_w_q;
	logic [6:0] sf_q;
	logic sf_pend_q;

	gccl_sync3 u_sync_dcl (.clock_i(clock_i), .rst_n_i(rst_n_i), .pin_i(dcl_i), .level_o(dcl_s));
	gccl_sync3 u_sync_fsc (.clock_i(clock_i), .rst_n_i(rst_n_i), .pin_i(fsc_i), .level_o(fsc_s));
	gccl_sync3 u_sync_din (.clock_i(clock_i), .rst_n_i(rst_n_i), .pin_i(din_i), .level_o(din_s));
	gccl_sync3 u_sync_ms (.clock_i(clock_i), .rst_n_i(rst_n_i), .pin_i(master_i), .level_o(ms_s));

	// slave frames start on a sync rise, master frames free-run
	assign dcl_rise = dcl_s && !dcl_d_q;
	assign fsc_start = !ms_s && fsc_s && !fsc_d_q;
	assign idx = fsc_start ? 5'h00 : bcnt_q;
	assign frm_edge = dcl_rise && idx == 5'h00;
	assign ci_pos = gccl_pkg::CI_LAST_BIT - idx;

	// bit position within the frame
	always_ff @(posedge clock_i) begin
		if (!rst_n_i) begin
			dcl_d_q <= 1'b0;
			fsc_d_q <= 1'b0;
			bcnt_q <= 5'h00;
		end else begin
			dcl_d_q <= dcl_s;
			if (dcl_rise) begin
				fsc_d_q <= fsc_s;
				bcnt_q <= idx + 5'h01;
			end
		end
	end

	// ----------------------------------------------------------------
	// superframe alignment
	// ----------------------------------------------------------------
	logic lt_q;
	logic single_seen;

	// a sync pulse one dcl wide marks the first 2b+d of the superframe
	assign single_seen = dcl_rise && !ms_s && lt_q && !fsc_s && fsc_d_q && fsc_w_q == 2'h1;

	always_ff @(posedge clock_i) begin
		if (!rst_n_i) begin
			fsc_w_q <= 2'h0;
			sf_q <= 7'h00;
			tx_sf_first_o <= 1'b0;
		end else begin
			tx_sf_first_o <= 1'b0;
			if (dcl_rise) begin
				fsc_w_q <= fsc_s ? ((fsc_w_q == 2'h3) ? fsc_w_q : fsc_w_q + 2'h1) : 2'h0;
			end
			if (single_seen) begin
				sf_q <= 7'h00;
				tx_sf_first_o <= 1'b1;
			end else if (frm_edge) begin
				// without forced pulses the superframe runs on its own count
				sf_q <= (sf_q == gccl_pkg::SF_LAST_FRAME) ? 7'h00 : sf_q + 7'h01;
				tx_sf_first_o <= (sf_q == gccl_pkg::SF_LAST_FRAME);
			end
		end
	end

	// master sync: two dcl wide, one dcl wide on a superframe start
	always_ff @(posedge clock_i) begin
		if (!rst_n_i) begin
			fsc_o <= 1'b0;
			fsc_oe_o <= 1'b0;
			sf_pend_q <= 1'b0;
			single_fsc_q <= 1'b0;
		end else begin
			fsc_oe_o <= ms_s;
			if (frm_edge) begin
				single_fsc_q <= sf_pend_q || rx_sf_first_i;
				sf_pend_q <= 1'b0;
			end else if (rx_sf_first_i) begin
				sf_pend_q <= 1'b1;
			end
			if (dcl_rise) begin
				fsc_o <= ms_s && (idx == 5'h00 || (idx == 5'h01 && !single_fsc_q));
			end
		end
	end

	// ----------------------------------------------------------------
	// received c/i codes
	// ----------------------------------------------------------------
	logic [3:0] ci_sh_q, ci_last_q, ci_cmd_q, ci_new;
	logic ci_done;

	assign ci_new = {ci_sh_q[2:0], din_s};
	assign ci_done = dcl_rise && idx == gccl_pkg::CI_LAST_BIT;

	// bit 4 arrives first and lands in the msb
	always_ff @(posedge clock_i) begin
		if (!rst_n_i) begin
			ci_sh_q <= 4'hf;
			ci_last_q <= 4'hf;
			ci_cmd_q <= 4'hf;
		end else begin
			if (dcl_rise && idx >= gccl_pkg::CI_FIRST_BIT && idx <= gccl_pkg::CI_LAST_BIT) begin
				ci_sh_q <= ci_new;
			end
			if (ci_done) begin
				ci_last_q <= ci_new;
				if (ci_new == ci_last_q) begin
					ci_cmd_q <= ci_new;
				end
			end
		end
	end

	ci_confirm_a: assert property (@(posedge clock_i) disable iff (!rst_n_i)
		$changed(ci_cmd_q) |-> $past(ci_done) && $past(ci_new) == $past(ci_last_q))
		else $error("c/i command taken without two equal frames");

	// auxiliary pins follow the confirmed command
	always_ff @(posedge clock_i) begin
		if (!rst_n_i) begin
			aux_output_one_o <= 1'b0;
			aux_output_two_o <= 1'b0;
		end else begin
			aux_output_one_o <= (ci_cmd_q == gccl_pkg::CI_AUX_HIGH_ONE);
			aux_output_two_o <= (ci_cmd_q == gccl_pkg::CI_AUX_HIGH_TWO);
		end
	end

	aux_pins_a: assert property (@(posedge clock_i) disable iff (!rst_n_i)
		(ci_cmd_q == gccl_pkg::CI_AUX_HIGH_ONE) [*2] |-> aux_output_one_o && !aux_output_two_o)
		else $error("first auxiliary pin not held high");

	// ----------------------------------------------------------------
	// checked maintenance registers
	// ----------------------------------------------------------------
	logic [7:0] m4_rx_reg, m56_rx_reg;
	logic [11:0] eoc_msg_reg;
	logic upd_m4, upd_m56, upd_eoc;

	gccl_tri_chk #(.W(8)) u_chk_m4 (.clock_i(clock_i), .rst_n_i(rst_n_i),
		.stb_i(maint_i.stb), .val_i(maint_i.m4), .reg_o(m4_rx_reg), .upd_o(upd_m4));
	gccl_tri_chk #(.W(8)) u_chk_m56 (.clock_i(clock_i), .rst_n_i(rst_n_i),
		.stb_i(maint_i.stb), .val_i(maint_i.m56), .reg_o(m56_rx_reg), .upd_o(upd_m56));
	gccl_tri_chk #(.W(12)) u_chk_eoc (.clock_i(clock_i), .rst_n_i(rst_n_i),
		.stb_i(eoc_i.stb), .val_i(eoc_i.msg), .reg_o(eoc_msg_reg), .upd_o(upd_eoc));

	// ----------------------------------------------------------------
	// monitor channel sender
	// ----------------------------------------------------------------
	logic [2:0] pend_q, pend_clr;
	logic [15:0] msg_q;
	logic [1:0] phase_q;
	logic busy_q, mon_free;
	logic [7:0] mon_byte;

	// a byte goes out twice, first byte then second, msb first
	assign mon_free = !busy_q || phase_q == gccl_pkg::MON_LAST_PHASE;
	assign mon_byte = !busy_q ? gccl_pkg::MON_IDLE : (phase_q[1] ? msg_q[7:0] : msg_q[15:8]);

	// pick one indication per message slot, m4 first
	always_comb begin
		pend_clr = 3'b000;
		if (frm_edge && mon_free) begin
			if (pend_q[0]) begin
				pend_clr = 3'b001;
			end else if (pend_q[1]) begin
				pend_clr = 3'b010;
			end else if (pend_q[2]) begin
				pend_clr = 3'b100;
			end
		end
	end

	// a new change wins over the clear of the same flag
	always_ff @(posedge clock_i) begin
		if (!rst_n_i) begin
			pend_q <= 3'b000;
		end else begin
			pend_q <= (pend_q & ~pend_clr) | {upd_eoc, upd_m56, upd_m4};
		end
	end

	always_ff @(posedge clock_i) begin
		if (!rst_n_i) begin
			msg_q <= 16'hffff;
			phase_q <= 2'h0;
			busy_q <= 1'b0;
			resp_ready_o <= 1'b0;
		end else begin
			resp_ready_o <= 1'b0;
			if (frm_edge) begin
				phase_q <= phase_q + 2'h1;
				if (mon_free) begin
					phase_q <= 2'h0;
					busy_q <= 1'b1;
					if (pend_clr[0]) begin
						msg_q <= {gccl_pkg::HDR_M4, m4_rx_reg};
					end else if (pend_clr[1]) begin
						msg_q <= {gccl_pkg::HDR_M56, m56_rx_reg};
					end else if (pend_clr[2]) begin
						// a1 leads at b13, i8 trails at b2
						msg_q <= {gccl_pkg::HDR_EOC, eoc_msg_reg};
					end else if (resp_valid_i) begin
						msg_q <= resp_msg_i;
						resp_ready_o <= 1'b1;
					end else begin
						busy_q <= 1'b0;
					end
				end
			end
		end
	end

	resp_after_ind_a: assert property (@(posedge clock_i) disable iff (!rst_n_i)
		resp_ready_o |-> $past(pend_q) == 3'b000)
		else $error("response sent while indication pending");

	m4_format_a: assert property (@(posedge clock_i) disable iff (!rst_n_i)
		(frm_edge && mon_free && pend_q[0]) |=> msg_q == {8'h20, $past(m4_rx_reg)}
		&& (!pend_q[0] || $past(upd_m4)))
		else $error("m4 indication wrong or flag not cleared");

	m56_format_a: assert property (@(posedge clock_i) disable iff (!rst_n_i)
		(frm_edge && mon_free && pend_q[1:0] == 2'b10) |=> msg_q == {8'h00, $past(m56_rx_reg)})
		else $error("m5/m6 indication has wrong bytes");

	eoc_format_a: assert property (@(posedge clock_i) disable iff (!rst_n_i)
		(frm_edge && mon_free && pend_q == 3'b100) |=> msg_q == {4'h4, $past(eoc_msg_reg)})
		else $error("eoc indication has wrong bytes");

	// ----------------------------------------------------------------
	// activation and c/i indications
	// ----------------------------------------------------------------
	gccl_pkg::gccl_act_e st_q;
	logic [3:0] ci_ind_q, ind_d;
	logic arl_q;

	always_ff @(posedge clock_i) begin
		if (!rst_n_i) begin
			st_q <= gccl_pkg::ST_IDLE;
			arl_q <= 1'b0;
		end else if (ci_cmd_q == gccl_pkg::CI_CHIP_CLEAR) begin
			st_q <= gccl_pkg::ST_IDLE;
		end else begin
			case (st_q)
				gccl_pkg::ST_IDLE: begin
					if (ci_cmd_q == gccl_pkg::CI_ACT_REQUEST || ci_cmd_q == gccl_pkg::CI_ACT_LOOPBACK
						|| (!lt_q && linkup_i)) begin
						st_q <= gccl_pkg::ST_WAIT;
					end
				end
				gccl_pkg::ST_WAIT: begin
					if (linkup_i) begin
						st_q <= gccl_pkg::ST_LINE;
						arl_q <= !lt_q && eoc_lpbk_i;
					end
				end
				gccl_pkg::ST_LINE: begin
					if (lt_q ? m4_rx_reg[gccl_pkg::M4_ACT] : ci_cmd_q == gccl_pkg::CI_ACT_NOTICE) begin
						st_q <= gccl_pkg::ST_ACTIVE;
					end else if (!linkup_i) begin
						st_q <= gccl_pkg::ST_WAIT;
					end
				end
				gccl_pkg::ST_ACTIVE: begin
					if (lt_q ? ci_cmd_q == gccl_pkg::CI_DEACT_REQUEST : !m4_rx_reg[gccl_pkg::M4_DEA]) begin
						st_q <= gccl_pkg::ST_DEACT;
					end
				end
				gccl_pkg::ST_DEACT: begin
					if (ci_cmd_q == gccl_pkg::CI_DEACT_DONE) begin
						st_q <= gccl_pkg::ST_IDLE;
					end
				end
				default: begin
					st_q <= gccl_pkg::ST_IDLE;
				end
			endcase
		end
	end

	// line faults outrank the state's own indication outside idle
	always_comb begin
		case (st_q)
			gccl_pkg::ST_LINE: begin
				if (!lt_q) begin
					ind_d = arl_q ? gccl_pkg::CI_ACT_LOOPBACK : gccl_pkg::CI_ACT_REQUEST;
				end else if (m4_rx_reg[gccl_pkg::M4_SAI]) begin
					ind_d = gccl_pkg::CI_ACT_REQUEST;
				end else begin
					ind_d = gccl_pkg::CI_LINE_ONLY;
				end
			end
			gccl_pkg::ST_ACTIVE: begin
				ind_d = (!lt_q && lpbk_on_i) ? gccl_pkg::CI_LOOPBACK_ACTIVE : gccl_pkg::CI_ACT_NOTICE;
			end
			gccl_pkg::ST_DEACT: begin
				ind_d = lt_q ? gccl_pkg::CI_SHUTDOWN_ACCEPTED : gccl_pkg::CI_DEACT_REQUEST;
			end
			default: begin
				ind_d = gccl_pkg::CI_DEACT_DONE;
			end
		endcase
		if (st_q != gccl_pkg::ST_IDLE && sync_lost_i) begin
			ind_d = gccl_pkg::CI_RESYNC_NEEDED;
		end else if (st_q != gccl_pkg::ST_IDLE && line_err_i) begin
			ind_d = gccl_pkg::CI_ERROR_NOTICE;
		end
	end

	always_ff @(posedge clock_i) begin
		if (!rst_n_i) begin
			ci_ind_q <= gccl_pkg::CI_DEACT_DONE;
		end else begin
			ci_ind_q <= ind_d;
		end
	end

	loop_notice_a: assert property (@(posedge clock_i) disable iff (!rst_n_i)
		(st_q == gccl_pkg::ST_ACTIVE && !lt_q && lpbk_on_i && !sync_lost_i && !line_err_i)
		|=> ci_ind_q == 4'he)
		else $error("loopback notice missing while loopback on");

	sai_blocks_a: assert property (@(posedge clock_i) disable iff (!rst_n_i)
		(st_q == gccl_pkg::ST_LINE && lt_q && m4_rx_reg[4] && !sync_lost_i && !line_err_i)
		|=> ci_ind_q == 4'h8)
		else $error("line-only notice issued with sai set");

	// ----------------------------------------------------------------
	// transmit frame: monitor byte and c/i repeated every frame
	// ----------------------------------------------------------------
	always_ff @(posedge clock_i) begin
		if (!rst_n_i) begin
			dout_o <= 1'b1;
		end else if (dcl_rise) begin
			if (idx >= gccl_pkg::MON_FIRST_BIT && idx <= gccl_pkg::MON_LAST_BIT) begin
				dout_o <= mon_byte[3'h7 - idx[2:0]];
			end else if (idx >= gccl_pkg::CI_FIRST_BIT && idx <= gccl_pkg::CI_LAST_BIT) begin
				dout_o <= ci_ind_q[ci_pos[1:0]];
			end else begin
				dout_o <= 1'b1;
			end
		end
	end

	// ----------------------------------------------------------------
	// registers and automatic m4 bits
	// ----------------------------------------------------------------
	logic [7:0] m4_mask_q, m4_val_q, m4_auto;
	logic [7:0] rb_ctrl_q;

	assign lt_q = rb_ctrl_q[0];

	always_ff @(posedge clock_i) begin
		if (!rst_n_i) begin
			rb_ctrl_q <= gccl_pkg::RST_CTRL;
			m4_mask_q <= gccl_pkg::RST_M4_MASK;
			m4_val_q <= gccl_pkg::RST_M4_VAL;
		end else if (rbus_i.wr) begin
			case (rbus_i.addr)
				gccl_pkg::REG_CTRL: rb_ctrl_q <= rbus_i.wdata;
				gccl_pkg::REG_M4_MASK: m4_mask_q <= rbus_i.wdata;
				gccl_pkg::REG_M4_VAL: m4_val_q <= rbus_i.wdata;
				default: begin
				end
			endcase
		end
	end

	// status bits come from activation progress; uoa from the confirmed c/i command
	always_comb begin
		m4_auto = gccl_pkg::M4_FIXED_ONES;
		m4_auto[gccl_pkg::M4_ACT] = (st_q == gccl_pkg::ST_ACTIVE);
		m4_auto[gccl_pkg::M4_DEA] = !(lt_q && st_q == gccl_pkg::ST_DEACT);
		m4_auto[gccl_pkg::M4_UOA] = !(lt_q && ci_cmd_q == gccl_pkg::CI_LINE_ONLY);
		m4_auto[gccl_pkg::M4_SAI] = !lt_q && st_q != gccl_pkg::ST_IDLE;
	end

	always_ff @(posedge clock_i) begin
		if (!rst_n_i) begin
			m4_tx_o <= gccl_pkg::RST_M4_VAL;
			rb_rdata_o <= 8'h00;
		end else begin
			m4_tx_o <= (m4_auto & ~m4_mask_q) | (m4_val_q & m4_mask_q);
			rb_rdata_o <= 8'h00;
			if (rbus_i.rd) begin
				case (rbus_i.addr)
					gccl_pkg::REG_CTRL: rb_rdata_o <= rb_ctrl_q;
					gccl_pkg::REG_M4_MASK: rb_rdata_o <= m4_mask_q;
					gccl_pkg::REG_M4_VAL: rb_rdata_o <= m4_val_q;
					gccl_pkg::REG_M4_RX: rb_rdata_o <= m4_rx_reg;
					gccl_pkg::REG_M56_RX: rb_rdata_o <= m56_rx_reg;
					gccl_pkg::REG_EOC_LO: rb_rdata_o <= eoc_msg_reg[7:0];
					gccl_pkg::REG_EOC_HI: rb_rdata_o <= {4'h0, eoc_msg_reg[11:8]};
					gccl_pkg::REG_STATUS: rb_rdata_o <= {busy_q, ms_s, 1'b0, pend_q, aux_output_two_o,
						aux_output_one_o};
					gccl_pkg::REG_CI: rb_rdata_o <= {ci_cmd_q, ci_ind_q};
					default: rb_rdata_o <= 8'h00;
				endcase
			end
		end
	end

	m4_override_a: assert property (@(posedge clock_i) disable iff (!rst_n_i)
		((m4_mask_q == 8'hff) [*2]) |-> m4_tx_o == $past(m4_val_q))
		else $error("m4 override not applied");
endmodule

`default_nettype wire

// ===== test/gccl_l2_model.sv
// layer-2 controller model: sends c/i commands, decodes dout
// assumes slave mode, a free dcl and 32-bit frames
`default_nettype none

module gccl_l2_model (
	// link
	output logic dcl_o,
	output logic fsc_o,
	output logic din_o,
	input wire logic dout_i,
	// command in, decoded channels out
	input wire logic [3:0] cmd_i,
	output logic [3:0] ind_o,
	output logic [7:0] mon_o
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [4:0] bit_q = 5'h1f;
	logic [6:0] sr_q = 7'h7f;
	initial begin
		dcl_o = 1'b0;
		fsc_o = 1'b0;
		din_o = 1'b1;
		ind_o = 4'hf;
		mon_o = 8'hff;
	end
	always #80 dcl_o = ~dcl_o;
	// drive on the fall so lines are settled at the rise
	always @(negedge dcl_o) begin
		bit_q <= bit_q + 5'h01;
		// fixed two-wide sync from time zero, so alignment never moves
		fsc_o <= (bit_q == 5'h1f) || (bit_q == 5'h00);
		din_o <= (bit_q >= 5'h19 && bit_q <= 5'h1c) ? cmd_i[5'h1c - bit_q] : 1'b1;
	end
	// dout lags a bit, so each rise carries the previous bit
	always @(posedge dcl_o) begin
		sr_q <= {sr_q[5:0], dout_i};
		if (bit_q == 5'h1e) ind_o <= {sr_q[2:0], dout_i};
		if (bit_q == 5'h18) mon_o <= {sr_q, dout_i};
	end
endmodule

`default_nettype wire

// ===== test/gccl_ctrl_test.sv
// bench of gccl_ctrl: c/i flow, aux pins, monitor indications
// assumes slave mode with the l2 model on the link; nt first, lt at the end
`default_nettype none

module gccl_ctrl_test;
	timeunit 1ns;
	timeprecision 1ns;
	logic clock_i = 1'b0;
	logic rst_n_i = 1'b0;
	logic dcl, fsc, din, dout, aux1, aux2, linkup = 1'b0, lerr = 1'b0, lpe = 1'b0, lpo = 1'b0;
	logic slost = 1'b0, rv = 1'b0, rdy, fo, foe;
	logic [7:0] m4t;
	logic [3:0] cmd = 4'hf;
	logic [3:0] ind;
	logic [7:0] mon, rdata, v, m4, m56, pm4;
	logic [11:0] eoc;
	logic [31:0] seed = 32'h0000000d;
	gccl_pkg::gccl_maint_s maint = '0;
	gccl_pkg::gccl_eoc_s eoc_s = '0;
	gccl_pkg::gccl_rbus_s rbus = '0;
	int n_errors = 0;
	int n_tests = 0;
	always #10 clock_i = ~clock_i;
	// the read response stands until the design takes it
	always @(posedge clock_i) begin
		if (rdy) rv <= 1'b0;
	end
	gccl_ctrl DUT (.clock_i(clock_i), .rst_n_i(rst_n_i), .dcl_i(dcl), .fsc_i(fsc), .din_i(din),
		.master_i(1'b0), .dout_o(dout), .fsc_o(fo), .fsc_oe_o(foe), .maint_i(maint), .eoc_i(eoc_s),
		.rx_sf_first_i(1'b0), .linkup_i(linkup), .sync_lost_i(slost), .line_err_i(lerr),
		.eoc_lpbk_i(lpe), .lpbk_on_i(lpo), .tx_sf_first_o(), .m4_tx_o(m4t), .resp_valid_i(rv),
		.resp_msg_i(16'h13c6), .resp_ready_o(rdy), .aux_output_one_o(aux1),
		.aux_output_two_o(aux2), .rbus_i(rbus), .rb_rdata_o(rdata));
	gccl_l2_model PEER (.dcl_o(dcl), .fsc_o(fsc), .din_o(din), .dout_i(dout), .cmd_i(cmd),
		.ind_o(ind), .mon_o(mon));
	function automatic logic [31:0] xs(input logic [31:0] s);
		s = s ^ (s << 13);
		s = s ^ (s >> 17);
		return s ^ (s << 5);
	endfunction
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		n_tests++;
		if (got !== exp) begin
			n_errors++;
			$display("BAD %0t got %h want %h", $time, got, exp);
		end
	endtask
	task automatic frames(input int n);
		repeat (n * 256) @(posedge clock_i);
	endtask
	// a code needs two frames, then one more to come back
	task automatic ci(input logic [3:0] c, input logic [3:0] e);
		@(posedge clock_i);
		cmd <= c;
		frames(5);
		chk({4'h0, ind}, {4'h0, e});
	endtask
	task automatic seek(input logic [7:0] b);
		for (int i = 0; i < 8 && mon !== b; i++) frames(1);
		chk(mon, b);
	endtask
	task automatic rd(input logic [3:0] a);
		@(posedge clock_i);
		rbus <= '{1'b0, 1'b1, a, 8'h00};
		@(posedge clock_i);
		rbus <= '0;
		#1 v = rdata;
	endtask
	task automatic wr(input logic [3:0] a, input logic [7:0] d);
		@(posedge clock_i);
		rbus <= '{1'b1, 1'b0, a, d};
		@(posedge clock_i);
		rbus <= '0;
	endtask
	task automatic strobe(input int n);
		repeat (n) begin
			@(posedge clock_i);
			maint <= '{1'b1, m4, m56};
			eoc_s <= '{1'b1, eoc};
			@(posedge clock_i);
			maint.stb <= 1'b0;
			eoc_s.stb <= 1'b0;
			repeat (8) @(posedge clock_i);
		end
	endtask
	task automatic report_and_stop;
		$display("tests %0d errors %0d", n_tests, n_errors);
		if (n_errors == 0 && n_tests > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask
	// main sequence: c/i walk, then two random maintenance rounds
	initial begin
		pm4 = 8'hff;
		repeat (16) @(posedge clock_i);
		rst_n_i <= 1'b1;
		frames(3);
		chk({4'h0, ind}, 8'h0f);
		ci(4'h3, 4'hf);
		chk({7'h0, aux1}, 8'h01);
		ci(4'h2, 4'hf);
		chk({6'h0, aux2, aux1}, 8'h02);
		linkup <= 1'b1;
		lpe <= 1'b1;
		ci(4'h8, 4'ha);
		lpe <= 1'b0;
		ci(4'hc, 4'hc);
		lpo <= 1'b1;
		ci(4'hc, 4'he);
		lpo <= 1'b0;
		lerr <= 1'b1;
		ci(4'hc, 4'h5);
		lerr <= 1'b0;
		slost <= 1'b1;
		ci(4'hc, 4'h4);
		slost <= 1'b0;
		linkup <= 1'b0;
		ci(4'h1, 4'hf);
		$display("c/i test done");
		repeat (2) begin
			seed = xs(seed);
			m4 = {1'b0, seed[6:0]} | 8'h01;
			m56 = {1'b0, seed[14:8]} | 8'h01;
			eoc = {seed[27:17], 1'b0};
			strobe(2);
			rd(gccl_pkg::REG_M4_RX);
			chk(v, pm4);
			strobe(1);
			rv <= 1'b1;
			seek(8'h20);
			seek(m4);
			seek(8'h00);
			seek(m56);
			seek({4'h4, eoc[11:8]});
			seek(eoc[7:0]);
			seek(8'h13);
			seek(8'hc6);
			rd(gccl_pkg::REG_STATUS);
			chk(v & 8'h1c, 8'h00);
			pm4 = m4;
			$display("maintenance round done");
		end
		wr(gccl_pkg::REG_CTRL, 8'h01);
		linkup <= 1'b1;
		ci(4'h8, pm4[4] ? 4'h8 : 4'h7);
		wr(gccl_pkg::REG_M4_MASK, 8'hff);
		wr(gccl_pkg::REG_M4_VAL, 8'h5a);
		repeat (2) @(posedge clock_i);
		chk(m4t, 8'h5a);
		chk({6'h0, fo, foe}, 8'h00);
		$display("lt and override test done");
		report_and_stop;
	end
	// run needs about 80 frames; the limit leaves wide margin
	initial begin
		#1500000;
		n_errors++;
		report_and_stop;
	end
endmodule

`default_nettype wire
